// >>> include/ofp_defines.svh
// Register map, field positions, reset values and debounce timing
// Assumes the includer runs on a 20 MHz system clock
`ifndef OFP_DEFINES_SVH
`define OFP_DEFINES_SVH

`define OFP_ADDR_DEBOUNCE 8'h17
`define OFP_ADDR_UNDER_ST 8'h1a
`define OFP_ADDR_OVER_ST 8'h1b
`define OFP_ADDR_CH5CFG 8'h22
`define OFP_ADDR_CHON 8'h30

`define OFP_UNDER_SEL_LSB 0
`define OFP_OVER_SEL_LSB 2
`define OFP_CH5_SOLO_BIT 0
`define OFP_CH5_SEL_LSB 1
`define OFP_CH5_IDX 4

`define OFP_DEBOUNCE_RST 8'h00
`define OFP_CH5CFG_RST 8'h00
`define OFP_CHON_RST 7'h00
`define OFP_DLY_OFF 2'h3

`define OFP_CLK_MHZ 20
`define OFP_DLY0_US 8
`define OFP_DLY1_US 16
`define OFP_DLY2_US 64
`define OFP_DLY0_CYC (`OFP_DLY0_US * `OFP_CLK_MHZ)
`define OFP_DLY1_CYC (`OFP_DLY1_US * `OFP_CLK_MHZ)
`define OFP_DLY2_CYC (`OFP_DLY2_US * `OFP_CLK_MHZ)

`endif

// >>> include/ofp_pkg.sv
// Shared types of the output fault protection block
// Assumes ofp_defines.svh supplies all numeric constants
package ofp_pkg;
    typedef logic [1:0] dly_sel_t;
    typedef enum logic {PROT_RUN, PROT_LOCKED} prot_state_t;
endpackage

// >>> logic/fault_debounce.sv
// One detector debouncer: qualifies a raw fault after a selected delay
// Assumes the raw input is synchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "ofp_defines.svh"
module fault_debounce
    import ofp_pkg::*;
#(
    parameter int CNT_W = 11
) (
    input wire logic clk_sys_i,  // System clock
    input wire logic srst_i,     // Synchronous reset, high
    input wire logic raw_i,      // Raw detector level
    input wire dly_sel_t sel_i,  // Delay select, 3 disables
    output logic qual_o          // Qualified fault level
);
    localparam logic [CNT_W-1:0] LIM0 = CNT_W'(`OFP_DLY0_CYC - 1);
    localparam logic [CNT_W-1:0] LIM1 = CNT_W'(`OFP_DLY1_CYC - 1);
    localparam logic [CNT_W-1:0] LIM2 = CNT_W'(`OFP_DLY2_CYC - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic qual_reg;
    logic [CNT_W-1:0] lim;
    wire logic off = (sel_i == `OFP_DLY_OFF);
    wire logic hit = (cnt_reg == lim);

    assign lim = (sel_i == 2'h0) ? LIM0 : (sel_i == 2'h1) ? LIM1 : LIM2;
    assign qual_o = qual_reg;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i || off || !raw_i) begin
            // Any gap in the fault starts the wait over
            cnt_reg <= '0;
            qual_reg <= 1'b0;
        end else if (hit) begin
            qual_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end
endmodule
`default_nettype wire

// >>> logic/sticky_flags.sv
// Bank of sticky status flags, write-one-to-clear
// Assumes set and clear are one-cycle terms in the clk_sys_i domain
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
    parameter int W = 7
) (
    input wire logic clk_sys_i,    // System clock
    input wire logic srst_i,       // Synchronous reset, high
    input wire logic [W-1:0] set_i,  // Set terms
    input wire logic [W-1:0] clr_i,  // Clear terms
    output logic [W-1:0] flag_o      // Flag levels
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            logic flag_reg;
            assign flag_o[i] = flag_reg;
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    flag_reg <= 1'b0;
                end else begin
                    // A fault in the clearing cycle keeps the flag
                    flag_reg <= set_i[i] | (flag_reg & ~clr_i[i]);
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> logic/output_fault_protection.sv
// Output fault protection: debounced under/over detection, channel-on
// control and sticky fault status behind a byte register port.
// Assumes an outside serial-bus slave presents byte address/data
// strobes on clk_sys_i, and comparator levels are synchronous.
// Function
// - A qualified undervoltage on channels 1-7 clears all channel-on bits
// - Undervoltage counts only after persisting for the selected delay
// - Undervoltage delay select 11 disables undervoltage protection
// - With channel 5 standalone, its undervoltage fault shuts down channel 5 only
// - Standalone channel 5 uses its own undervoltage delay select
// - After shutdown outputs stay off until enable goes low then high
// - Standalone channel 5 restarts alone by writing 1 to its bit
// - Undervoltage shutdown sets the faulting channel's sticky flag
// - Writing 1 clears an undervoltage flag; writing 0 leaves it
// - A qualified overvoltage on channels 1-6 clears channels 1-6
// - Overvoltage counts only after persisting for the selected delay
// - Overvoltage delay select 11 disables overvoltage protection
// - Overvoltage shutdown latches a per-channel write-1-clear flag
// - Writing 1 to a channel-on bit enables only while enable is high
`timescale 1ns/1ps
`default_nettype none
`include "ofp_defines.svh"
module output_fault_protection
    import ofp_pkg::*;
#(
    parameter int N_UNDER = 7,
    parameter int N_OVER = 6,
    parameter int CNT_W = 11
) (
    input wire logic clk_sys_i,              // System clock, 20 MHz
    input wire logic srst_i,                 // Synchronous reset, high
    input wire logic en_pin_i,               // Enable pin level
    input wire logic [N_UNDER-1:0] under_raw_i, // Undervoltage detectors
    input wire logic [N_OVER-1:0] over_raw_i,   // Overvoltage detectors
    input wire logic [7:0] reg_addr_i,       // Register address
    input wire logic [7:0] reg_wdata_i,      // Write data
    input wire logic reg_wr_i,               // Write strobe
    input wire logic reg_rd_i,               // Read strobe
    output logic [7:0] reg_rdata_o,          // Read data, held
    output logic [N_UNDER-1:0] channel_on_o, // Channel-on bits
    output logic lockout_o                   // Fault lockout active
);
    // Register state
    logic [7:0] debounce_reg;
    logic [7:0] ch5cfg_reg;
    logic [N_UNDER-1:0] channel_on_reg;
    logic [N_UNDER-1:0] channel_on_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic lockout_reg;
    prot_state_t state_reg;
    prot_state_t state_next;

    // Register decode
    wire logic wr_debounce = reg_wr_i && (reg_addr_i == `OFP_ADDR_DEBOUNCE);
    wire logic wr_ch5cfg = reg_wr_i && (reg_addr_i == `OFP_ADDR_CH5CFG);
    wire logic wr_chon = reg_wr_i && (reg_addr_i == `OFP_ADDR_CHON);
    wire logic wr_under_st = reg_wr_i && (reg_addr_i == `OFP_ADDR_UNDER_ST);
    wire logic wr_over_st = reg_wr_i && (reg_addr_i == `OFP_ADDR_OVER_ST);

    // Field extraction
    wire dly_sel_t under_debounce_sel =
        debounce_reg[`OFP_UNDER_SEL_LSB +: 2];
    wire dly_sel_t over_debounce_sel =
        debounce_reg[`OFP_OVER_SEL_LSB +: 2];
    wire logic chan5_standalone_under_sel = ch5cfg_reg[`OFP_CH5_SOLO_BIT];
    wire dly_sel_t chan5_under_debounce_sel =
        ch5cfg_reg[`OFP_CH5_SEL_LSB +: 2];

    // Qualified detector levels and sticky flags
    logic [N_UNDER-1:0] under_qual;
    logic [N_OVER-1:0] over_qual;
    logic [N_UNDER-1:0] under_fault_flag;
    logic [N_OVER-1:0] over_fault_flag;
    dly_sel_t under_sel_ch [N_UNDER];

    genvar i;
    generate
        for (i = 0; i < N_UNDER; i++) begin : g_under
            if (i == `OFP_CH5_IDX) begin : g_sel5
                // Own delay only while isolated
                assign under_sel_ch[i] = chan5_standalone_under_sel ?
                    chan5_under_debounce_sel : under_debounce_sel;
            end else begin : g_sel
                assign under_sel_ch[i] = under_debounce_sel;
            end
            // An off channel reads as under; only watch live ones
            fault_debounce #(
                .CNT_W(CNT_W)
            ) u_deb (
                .clk_sys_i(clk_sys_i),
                .srst_i(srst_i),
                .raw_i(under_raw_i[i] & channel_on_reg[i]),
                .sel_i(under_sel_ch[i]),
                .qual_o(under_qual[i])
            );
        end
        for (i = 0; i < N_OVER; i++) begin : g_over
            fault_debounce #(
                .CNT_W(CNT_W)
            ) u_deb (
                .clk_sys_i(clk_sys_i),
                .srst_i(srst_i),
                .raw_i(over_raw_i[i] & channel_on_reg[i]),
                .sel_i(over_debounce_sel),
                .qual_o(over_qual[i])
            );
        end
    endgenerate

    // Shutdown decisions
    logic [N_UNDER-1:0] ch5_mask;
    assign ch5_mask = N_UNDER'(1) << `OFP_CH5_IDX;

    wire logic [N_UNDER-1:0] under_global_src =
        chan5_standalone_under_sel ? (under_qual & ~ch5_mask) : under_qual;
    wire logic under_global = |under_global_src;
    wire logic under_solo5 = chan5_standalone_under_sel &&
        |(under_qual & ch5_mask);
    wire logic over_any = |over_qual;
    wire logic global_shut = under_global || over_any;

    logic [N_UNDER-1:0] over_mask;
    assign over_mask = N_UNDER'((1 << N_OVER) - 1);

    wire logic [N_UNDER-1:0] shut_mask =
        ({N_UNDER{under_global}})
        | ({N_UNDER{over_any}} & over_mask)
        | ({N_UNDER{under_solo5}} & ch5_mask);

    // Lockout refuses every enabling write until enable drops
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PROT_RUN: begin
                if (global_shut) begin
                    state_next = PROT_LOCKED;
                end
            end
            PROT_LOCKED: begin
                if (!en_pin_i) begin
                    state_next = PROT_RUN;
                end
            end
            default: begin
                state_next = PROT_RUN;
            end
        endcase
    end

    // Enabling writes need enable high and no lockout
    wire logic may_enable = en_pin_i && (state_reg == PROT_RUN)
        && !global_shut;
    wire logic [N_UNDER-1:0] chon_wdata = reg_wdata_i[N_UNDER-1:0];
    // Refused ones leave the bit as it was; zeros always switch off
    wire logic [N_UNDER-1:0] chon_written =
        may_enable ? chon_wdata : (channel_on_reg & chon_wdata);
    // A lone channel 5 restart rides the same path
    wire logic [N_UNDER-1:0] chon_after_wr =
        wr_chon ? chon_written : channel_on_reg;
    // Enable low drops every channel at once
    assign channel_on_next = en_pin_i ?
        (chon_after_wr & ~shut_mask) : `OFP_CHON_RST;

    // Sticky fault status
    sticky_flags #(
        .W(N_UNDER)
    ) u_under_st (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .set_i(under_qual),
        .clr_i(reg_wdata_i[N_UNDER-1:0] & {N_UNDER{wr_under_st}}),
        .flag_o(under_fault_flag)
    );

    sticky_flags #(
        .W(N_OVER)
    ) u_over_st (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .set_i(over_qual),
        .clr_i(reg_wdata_i[N_OVER-1:0] & {N_OVER{wr_over_st}}),
        .flag_o(over_fault_flag)
    );

    // Read mux; unmapped addresses read zero
    wire logic [7:0] under_st_rd = 8'(under_fault_flag);
    wire logic [7:0] over_st_rd = 8'(over_fault_flag);
    wire logic [7:0] chon_rd = 8'(channel_on_reg);
    wire logic [7:0] rd_mux =
        (reg_addr_i == `OFP_ADDR_DEBOUNCE) ? debounce_reg :
        (reg_addr_i == `OFP_ADDR_CH5CFG) ? ch5cfg_reg :
        (reg_addr_i == `OFP_ADDR_CHON) ? chon_rd :
        (reg_addr_i == `OFP_ADDR_UNDER_ST) ? under_st_rd :
        (reg_addr_i == `OFP_ADDR_OVER_ST) ? over_st_rd : 8'h00;
    assign rdata_next = reg_rd_i ? rd_mux : rdata_reg;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            debounce_reg <= `OFP_DEBOUNCE_RST;
            ch5cfg_reg <= `OFP_CH5CFG_RST;
        end else begin
            if (wr_debounce) begin
                debounce_reg <= {4'h0, reg_wdata_i[3:0]};
            end
            if (wr_ch5cfg) begin
                ch5cfg_reg <= {5'h00, reg_wdata_i[2:0]};
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            channel_on_reg <= `OFP_CHON_RST;
            state_reg <= PROT_RUN;
            lockout_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            channel_on_reg <= channel_on_next;
            state_reg <= state_next;
            lockout_reg <= (state_next == PROT_LOCKED);
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign channel_on_o = channel_on_reg;
    assign lockout_o = lockout_reg;
endmodule
`default_nettype wire

// >>> test/ofp_assertions.sv
// Port-level checks for output_fault_protection
// Assumes binding to the top module; delays are at least 160 cycles
`timescale 1ns/1ps
`default_nettype none
module ofp_assertions #(
    parameter int N_UNDER = 7,
    parameter int N_OVER = 6,
    parameter int CNT_W = 11
) (
    input wire logic clk_sys_i, // Clock
    input wire logic srst_i, // Reset
    input wire logic en_pin_i, // Enable
    input wire logic [N_UNDER-1:0] under_raw_i, // UV raw
    input wire logic [N_OVER-1:0] over_raw_i, // OV raw
    input wire logic [7:0] reg_addr_i, // Address
    input wire logic [7:0] reg_wdata_i, // Data
    input wire logic reg_wr_i, // Write
    input wire logic reg_rd_i, // Read
    input wire logic [7:0] reg_rdata_o, // Read data
    input wire logic [N_UNDER-1:0] channel_on_o, // Channels
    input wire logic lockout_o // Lockout
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    localparam int MIN_CYC = 160;
    logic [11:0] run_cnt;
    wire u_live = |(under_raw_i & channel_on_o);
    wire live = u_live || (|(over_raw_i & channel_on_o[N_OVER-1:0]));
    wire chon_wr = reg_wr_i && (reg_addr_i == 8'h30);
    // Any-channel run length is an upper bound on every channel's run
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !live) begin
            run_cnt <= 12'h000;
        end else if (run_cnt != 12'hfff) begin
            run_cnt <= run_cnt + 12'h001;
        end
    end
    property p_en_off;
        !en_pin_i |=> channel_on_o == '0;
    endproperty
    property p_zero_wr;
        chon_wr && (reg_wdata_i == 8'h00) |=> channel_on_o == '0;
    endproperty
    property p_lock_hold;
        lockout_o && en_pin_i |=> (channel_on_o & ~$past(channel_on_o)) == '0;
    endproperty
    property p_lock_rel;
        lockout_o && !en_pin_i |-> ##[1:2] !lockout_o;
    endproperty
    property p_new_on;
        (channel_on_o & ~$past(channel_on_o)) != '0
            |-> $past(chon_wr) && $past(en_pin_i);
    endproperty
    property p_shut;
        $rose(lockout_o) |-> channel_on_o[N_OVER-1:0] == '0;
    endproperty
    property p_delay;
        ((($past(channel_on_o) & ~channel_on_o) != '0) && $past(en_pin_i)
            && !$past(reg_wr_i) && !$past(srst_i))
            |-> $past(run_cnt) >= MIN_CYC;
    endproperty
    property p_rd_hold;
        !reg_rd_i |=> $stable(reg_rdata_o);
    endproperty
    a_en_off: assert property (p_en_off) else $error("on while disabled");
    a_zero_wr: assert property (p_zero_wr) else $error("zero write kept");
    a_lock_hold: assert property (p_lock_hold) else $error("lock bypass");
    a_lock_rel: assert property (p_lock_rel) else $error("lock stuck");
    a_new_on: assert property (p_new_on) else $error("on without write");
    a_shut: assert property (p_shut) else $error("lock left on");
    a_delay: assert property (p_delay) else $error("early trip");
    a_rd_hold: assert property (p_rd_hold) else $error("read moved");
    c_lock: cover property ($rose(lockout_o));
    c_solo: cover property ($fell(channel_on_o[4]) && !lockout_o);
    c_rel: cover property ($fell(lockout_o));
endmodule
bind output_fault_protection ofp_assertions #(.N_UNDER(N_UNDER),
    .N_OVER(N_OVER), .CNT_W(CNT_W)) chk_u (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .en_pin_i(en_pin_i), .under_raw_i(under_raw_i),
    .over_raw_i(over_raw_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .channel_on_o(channel_on_o),
    .lockout_o(lockout_o));
`default_nettype wire

// >>> test/rail_comparator_model.sv
// Rail comparator model feeding the detector inputs
// Assumes the bench sets fault requests on falling edges
`timescale 1ns/1ps
`default_nettype none
module rail_comparator_model (
    input wire logic [6:0] chan_on_i, // Rails powered
    input wire logic [6:0] uv_req_i, // Rails pulled low
    input wire logic [5:0] ov_req_i, // Rails pushed high
    output logic [6:0] under_o, // UV comparators
    output logic [5:0] over_o // OV comparators
);
    // An unpowered rail sits under threshold, as a real one does
    assign under_o = uv_req_i | ~chan_on_i;
    assign over_o = ov_req_i;
endmodule
`default_nettype wire

// >>> test/output_fault_protection_tb.sv
// Self-checking bench for output_fault_protection
// Assumes 160 and 1280 cycle debounce for selects 0 and 2
`timescale 1ns/1ps
`default_nettype none
module output_fault_protection_tb;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic en_pin_i = 1'b1;
    logic [6:0] under_raw_i;
    logic [5:0] over_raw_i;
    logic [6:0] uv = 7'h00;
    logic [5:0] ov = 6'h00;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [6:0] channel_on_o;
    logic lockout_o;
    int err_count = 0;
    int tests_run = 0;
    output_fault_protection dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .en_pin_i(en_pin_i), .under_raw_i(under_raw_i),
        .over_raw_i(over_raw_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .channel_on_o(channel_on_o),
        .lockout_o(lockout_o));
    rail_comparator_model cmp_u (.chan_on_i(channel_on_o), .uv_req_i(uv),
        .ov_req_i(ov), .under_o(under_raw_i), .over_o(over_raw_i));
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        chk(reg_rdata_o, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic on(input logic [6:0] e, input logic l);
        chk({lockout_o, channel_on_o}, {l, e});
    endtask
    // Writes while disabled must not enable anything
    task automatic toggle_en;
        en_pin_i = 1'b0;
        wr(8'h30, 8'h7f);
        on(7'h00, 1'b0);
        en_pin_i = 1'b1;
        wr(8'h30, 8'h7f);
        on(7'h7f, 1'b0);
    endtask
    task automatic t_reset;
        logic [7:0] am [6];
        am = '{8'h17, 8'h1a, 8'h1b, 8'h22, 8'h30, 8'h55};
        foreach (am[i]) rd(am[i], 8'h00);
        on(7'h00, 1'b0);
        $display("t_reset done");
    endtask
    task automatic t_uv;
        wr(8'h30, 8'h7f);
        uv = 7'h02;
        cyc(100);
        uv = 7'h00;
        cyc(2);
        uv = 7'h02;
        cyc(150);
        on(7'h7f, 1'b0);
        cyc(20);
        on(7'h00, 1'b1);
        uv = 7'h00;
        rd(8'h1a, 8'h02);
        wr(8'h30, 8'h7f);
        on(7'h00, 1'b1);
        wr(8'h1a, 8'h00);
        rd(8'h1a, 8'h02);
        wr(8'h1a, 8'h02);
        rd(8'h1a, 8'h00);
        toggle_en();
        $display("t_uv done");
    endtask
    task automatic t_ov;
        ov = 6'h04;
        cyc(170);
        on(7'h40, 1'b1);
        ov = 6'h00;
        rd(8'h1b, 8'h04);
        rd(8'h1a, 8'h00);
        wr(8'h1b, 8'h04);
        rd(8'h1b, 8'h00);
        toggle_en();
        $display("t_ov done");
    endtask
    task automatic t_off;
        wr(8'h17, 8'h0f);
        rd(8'h17, 8'h0f);
        uv = 7'h7f;
        ov = 6'h3f;
        cyc(300);
        on(7'h7f, 1'b0);
        uv = 7'h00;
        ov = 6'h00;
        rd(8'h1a, 8'h00);
        rd(8'h1b, 8'h00);
        wr(8'h17, 8'h00);
        $display("t_off done");
    endtask
    task automatic t_ch5;
        wr(8'h22, 8'h01);
        wr(8'h17, 8'h02);
        uv = 7'h10;
        cyc(170);
        on(7'h6f, 1'b0);
        rd(8'h30, 8'h6f);
        uv = 7'h00;
        rd(8'h1a, 8'h10);
        wr(8'h30, 8'h7f);
        on(7'h7f, 1'b0);
        uv = 7'h01;
        cyc(400);
        on(7'h7f, 1'b0);
        cyc(900);
        on(7'h00, 1'b1);
        uv = 7'h00;
        rd(8'h1a, 8'h11);
        wr(8'h1a, 8'h11);
        wr(8'h22, 8'h00);
        wr(8'h17, 8'h00);
        toggle_en();
        $display("t_ch5 done");
    endtask
    // Selects 1 and 3, and a zero write to the channel-on bits
    task automatic t_sel;
        wr(8'h30, 8'h00);
        on(7'h00, 1'b0);
        wr(8'h30, 8'h7f);
        wr(8'h22, 8'h07);
        rd(8'h22, 8'h07);
        wr(8'h17, 8'h05);
        uv = 7'h10;
        ov = 6'h01;
        cyc(310);
        on(7'h7f, 1'b0);
        cyc(20);
        on(7'h40, 1'b1);
        uv = 7'h00;
        ov = 6'h00;
        rd(8'h1b, 8'h01);
        rd(8'h1a, 8'h00);
        wr(8'h1b, 8'h01);
        wr(8'h22, 8'h00);
        wr(8'h17, 8'h00);
        toggle_en();
        $display("t_sel done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        cyc(4);
        srst_i = 1'b0;
        t_reset();
        t_uv();
        t_ov();
        t_off();
        t_ch5();
        t_sel();
        summarize();
    end
    initial begin
        repeat (10000) @(posedge clk_sys_i);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
